// ===== hw/rr_exec_pkg.sv
// Constants, types and register map of the return and rotate executor
package rr_exec_pkg;

  // ***************************************************************
  // Instruction cycle
  // ***************************************************************
  localparam logic [1:0] PHASE_Q1 = 2'h0;   // Decode
  localparam logic [1:0] PHASE_Q2 = 2'h1;   // Read operand
  localparam logic [1:0] PHASE_Q3 = 2'h2;   // Process
  localparam logic [1:0] PHASE_Q4 = 2'h3;   // Write back

  // ***************************************************************
  // Register map (byte addresses)
  // ***************************************************************
  localparam logic [11:0] OFF_INSTR     = 12'h000; // Opcode, starts it
  localparam logic [11:0] OFF_EXEC_STAT = 12'h004; // Busy, illegal
  localparam logic [11:0] OFF_WORK      = 12'h008; // Working register
  localparam logic [11:0] OFF_CPU_STAT  = 12'h00C; // CPU status
  localparam logic [11:0] OFF_ALU_STAT  = 12'h010; // Carry lives here
  localparam logic [11:0] OFF_PC        = 12'h014; // Program counter
  localparam logic [11:0] OFF_PC_HIGH   = 12'h018; // High latch
  localparam logic [11:0] OFF_STACK_TOP = 12'h01C; // Read-only view
  localparam logic [1:0]  MEM_SEL       = 2'h1;    // addr[11:10] = 01

  // ***************************************************************
  // Field positions and reset values
  // ***************************************************************
  localparam int          GLINT_BIT    = 4;      // Global irq disable
  localparam int          CARRY_BIT    = 0;      // Carry flag
  localparam int          BUSY_BIT     = 0;      // Execution running
  localparam int          ILLEGAL_BIT  = 1;      // Unknown opcode seen
  localparam logic [7:0]  CPU_STAT_RST = 8'h10;  // Interrupts off
  localparam logic [7:0]  ALU_STAT_RST = 8'h00;
  localparam logic [7:0]  WORK_RST     = 8'h00;
  localparam logic [15:0] PC_RST       = 16'h0000;
  localparam logic [7:0]  PC_HIGH_RST  = 8'h00;

  // ***************************************************************
  // Opcodes
  // ***************************************************************
  localparam logic [15:0] OP_RET_IRQ = 16'h0005; // return_from_irq
  localparam logic [15:0] OP_RET_SUB = 16'h0002; // Subroutine return
  localparam logic [7:0]  OP_RET_LIT = 8'hB6;    // return_with_literal
  localparam logic [6:0]  OP_ROT_LC  = 7'h0D;    // rotate_left_carry
  localparam logic        DEST_WORK  = 1'h0;     // Result to working

  // ***************************************************************
  // Bus answers and states
  // ***************************************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE     = 2'h0,   // Waiting for an opcode
    ST_EXEC     = 2'h1,   // First instruction cycle
    ST_IDLE_CYC = 2'h3    // Second, idle instruction cycle
  } exec_state_t;

endpackage

// ===== hw/file_ram.sv
// File register memory, 256 bytes, registered read data
module file_ram (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic [7:0] addr,
  input  wire logic       we,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata
);

  logic [7:0] mem [0:255];   // Storage, left uninitialised

  // Write port
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  // Read data leave through a flop, one cycle after the address
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= mem[addr];
    end
  end

endmodule // file_ram

// ===== hw/return_rotate_instr_exec.sv
// Executor for return and rotate-through-carry instructions
module return_rotate_instr_exec
  import rr_exec_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [15:0] stack_top,
  output logic             stack_pop
);

  // ***************************************************************
  // Reset release
  // ***************************************************************
  logic       rst_meta;              // First stage
  logic       rst_n;                 // Released copy used everywhere

  // Assertion is immediate, release waits two edges
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ***************************************************************
  // State
  // ***************************************************************
  exec_state_t state_reg, state_next;  // Instruction sequencer
  logic [1:0]  phase_reg;              // Q1..Q4 within a cycle
  logic [15:0] instr_reg;              // Opcode under execution
  logic [7:0]  operand_reg;            // File value latched in Q3
  logic [7:0]  work_reg, work_next;    // working_reg
  logic [7:0]  cpu_stat_reg, cpu_stat_next;  // cpu_status_reg
  logic [7:0]  alu_stat_reg, alu_stat_next;  // Holds carry
  logic [15:0] pc_reg, pc_next;        // Program counter
  logic [7:0]  pc_high_reg, pc_high_next;    // pc_high_latch
  logic        illegal_reg, illegal_next;    // Sticky decode error
  logic [11:0] aw_addr_reg;            // Held write address
  logic        aw_full_reg, w_full_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic [11:0] ar_addr_reg;            // Held read address
  logic        rd_wait_reg;            // Memory read in flight
  logic [7:0]  mem_rdata;

  // ***************************************************************
  // Decode
  // ***************************************************************
  wire busy      = (state_reg != ST_IDLE);
  wire in_exec   = (state_reg == ST_EXEC);
  wire q3        = in_exec && (phase_reg == PHASE_Q3);
  wire q4        = in_exec && (phase_reg == PHASE_Q4);
  wire is_ret_irq = (instr_reg == OP_RET_IRQ);
  wire is_ret_sub = (instr_reg == OP_RET_SUB);
  wire is_ret_lit = (instr_reg[15:8] == OP_RET_LIT);
  wire is_rot     = (instr_reg[15:9] == OP_ROT_LC);
  wire dest_file  = is_rot && (instr_reg[8] != DEST_WORK);
  wire is_return  = is_ret_irq || is_ret_sub || is_ret_lit;
  wire [7:0] rot_val = {operand_reg[6:0], alu_stat_reg[CARRY_BIT]};
  wire       rot_out = operand_reg[7];

  // ***************************************************************
  // Bus write path
  // ***************************************************************
  wire wr_fire  = aw_full_reg && w_full_reg && !bvalid && !busy;
  wire [11:0] wa = aw_addr_reg;
  wire wr_mem   = (wa[11:10] == MEM_SEL);
  wire wr_instr = wr_fire && (wa == OFF_INSTR);
  wire wr_stat  = wr_fire && (wa == OFF_EXEC_STAT);
  wire wr_work  = wr_fire && (wa == OFF_WORK) && w_strb_reg[0];
  wire wr_cpu   = wr_fire && (wa == OFF_CPU_STAT) && w_strb_reg[0];
  wire wr_alu   = wr_fire && (wa == OFF_ALU_STAT) && w_strb_reg[0];
  wire wr_pc    = wr_fire && (wa == OFF_PC);
  wire wr_high  = wr_fire && (wa == OFF_PC_HIGH) && w_strb_reg[0];
  wire wa_known = wr_mem || (wa == OFF_INSTR) || (wa == OFF_EXEC_STAT)
                  || (wa == OFF_WORK) || (wa == OFF_CPU_STAT)
                  || (wa == OFF_ALU_STAT) || (wa == OFF_PC)
                  || (wa == OFF_PC_HIGH) || (wa == OFF_STACK_TOP);
  wire opc_known = (w_data_reg[15:0] == OP_RET_IRQ)
                   || (w_data_reg[15:0] == OP_RET_SUB)
                   || (w_data_reg[15:8] == OP_RET_LIT)
                   || (w_data_reg[15:9] == OP_ROT_LC);
  wire start    = wr_instr && opc_known;

  assign awready = !aw_full_reg;
  assign wready  = !w_full_reg;

  // Address and data are held separately and may come in either order
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= awaddr;
      end else if (wr_fire) begin
        aw_full_reg <= 1'b0;
      end
      if (wvalid && wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end else if (wr_fire) begin
        w_full_reg <= 1'b0;
      end
    end
  end

  // Write response; unmapped addresses answer with a slave error
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp  <= wa_known ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ***************************************************************
  // Bus read path
  // ***************************************************************
  // Reads wait while an instruction runs, so no field moves under them
  assign arready = !rvalid && !rd_wait_reg && !busy
                   && !(aw_full_reg && w_full_reg && !bvalid);
  wire ar_fire = arvalid && arready;
  wire rd_mem  = (araddr[11:10] == MEM_SEL);
  logic [31:0] rd_mux;
  logic        rd_known;

  // Register read selection
  always_comb begin
    rd_known = 1'b1;
    rd_mux   = 32'h0000_0000;
    case (araddr)
      OFF_INSTR:     rd_mux = {16'h0000, instr_reg};
      OFF_EXEC_STAT: rd_mux = {30'h0000_0000, illegal_reg, busy};
      OFF_WORK:      rd_mux = {24'h00_0000, work_reg};
      OFF_CPU_STAT:  rd_mux = {24'h00_0000, cpu_stat_reg};
      OFF_ALU_STAT:  rd_mux = {24'h00_0000, alu_stat_reg};
      OFF_PC:        rd_mux = {16'h0000, pc_reg};
      OFF_PC_HIGH:   rd_mux = {24'h00_0000, pc_high_reg};
      OFF_STACK_TOP: rd_mux = {16'h0000, stack_top};
      default:       rd_known = 1'b0;
    endcase
  end

  // Registers answer next cycle, memory one cycle later
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rvalid      <= 1'b0;
      rdata       <= 32'h0000_0000;
      rresp       <= RESP_OKAY;
      rd_wait_reg <= 1'b0;
      ar_addr_reg <= 12'h000;
    end else if (ar_fire && rd_mem) begin
      rd_wait_reg <= 1'b1;
      ar_addr_reg <= araddr;
    end else if (ar_fire) begin
      rvalid <= 1'b1;
      rdata  <= rd_mux;
      rresp  <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (rd_wait_reg) begin
      rd_wait_reg <= 1'b0;
      rvalid      <= 1'b1;
      rdata       <= {24'h00_0000, mem_rdata};
      rresp       <= RESP_OKAY;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ***************************************************************
  // File register memory
  // ***************************************************************
  wire [7:0] mem_addr = busy    ? instr_reg[7:0] :
                        wr_fire ? wa[9:2] : araddr[9:2];
  wire mem_we = (q4 && dest_file) ||
                (wr_fire && wr_mem && w_strb_reg[0]);
  wire [7:0] mem_wdata = busy ? rot_val : w_data_reg[7:0];

  file_ram file_ram_inst (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .addr    (mem_addr),
    .we      (mem_we),
    .wdata   (mem_wdata),
    .rdata   (mem_rdata)
  );

  // ***************************************************************
  // Sequencer
  // ***************************************************************
  // Returns take a second, idle instruction cycle
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:     if (start) state_next = ST_EXEC;
      ST_EXEC:     if (phase_reg == PHASE_Q4) begin
                     state_next = is_return ? ST_IDLE_CYC : ST_IDLE;
                   end
      ST_IDLE_CYC: if (phase_reg == PHASE_Q4) state_next = ST_IDLE;
      default:     state_next = ST_IDLE;
    endcase
  end

  // Phase divider runs only while an instruction is in flight
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg   <= ST_IDLE;
      phase_reg   <= PHASE_Q1;
      instr_reg   <= 16'h0000;
      operand_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      phase_reg <= busy ? phase_reg + 2'h1 : PHASE_Q1;
      if (wr_instr) instr_reg <= w_data_reg[15:0];
      if (q3) operand_reg <= mem_rdata;
    end
  end

  // ***************************************************************
  // Architectural registers
  // ***************************************************************
  assign stack_pop = q4 && is_return;

  assign work_next = wr_work ? w_data_reg[7:0] :
                     (q4 && is_rot && !dest_file) ? rot_val :
                     (q4 && is_ret_lit) ? instr_reg[7:0] :
                     work_reg;
  always_comb begin
    cpu_stat_next = wr_cpu ? w_data_reg[7:0] : cpu_stat_reg;
    if (q3 && is_ret_irq) cpu_stat_next[GLINT_BIT] = 1'b0;
  end
  always_comb begin
    alu_stat_next = wr_alu ? w_data_reg[7:0] : alu_stat_reg;
    if (q4 && is_rot) alu_stat_next[CARRY_BIT] = rot_out;
  end
  // Only the popped value reaches the counter; the latch stays put
  assign pc_next = (q4 && is_return) ? stack_top :
                   {wr_pc && w_strb_reg[1] ? w_data_reg[15:8] : pc_reg[15:8],
                    wr_pc && w_strb_reg[0] ? w_data_reg[7:0] : pc_reg[7:0]};
  assign pc_high_next = wr_high ? w_data_reg[7:0] : pc_high_reg;
  // A new error outranks a clear in the same cycle
  assign illegal_next = (wr_instr && !opc_known) ||
                        (illegal_reg && !(wr_stat && w_strb_reg[0]
                                          && w_data_reg[ILLEGAL_BIT]));

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      work_reg     <= WORK_RST;
      cpu_stat_reg <= CPU_STAT_RST;
      alu_stat_reg <= ALU_STAT_RST;
      pc_reg       <= PC_RST;
      pc_high_reg  <= PC_HIGH_RST;
      illegal_reg  <= 1'b0;
    end else begin
      work_reg     <= work_next;
      cpu_stat_reg <= cpu_stat_next;
      alu_stat_reg <= alu_stat_next;
      pc_reg       <= pc_next;
      pc_high_reg  <= pc_high_next;
      illegal_reg  <= illegal_next;
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_irq_pop_pc: assert property (
    (q4 && is_ret_irq) |-> stack_pop ##1 (pc_reg == $past(stack_top)))
    else $error("interrupt return did not load stack top");
  a_high_latch_kept: assert property (
    busy |=> (pc_high_reg == $past(pc_high_reg)))
    else $error("high latch moved during execution");
  a_irq_enable: assert property (
    (q3 && is_ret_irq) |=> !cpu_stat_reg[GLINT_BIT]
      && (cpu_stat_reg[3:0] == $past(cpu_stat_reg[3:0]))
      && (cpu_stat_reg[7:5] == $past(cpu_stat_reg[7:5])))
    else $error("interrupt return status update wrong");
  a_decode_irq_ret: assert property (
    (q4 && instr_reg == OP_RET_IRQ) |=> (state_reg == ST_IDLE_CYC))
    else $error("interrupt return not decoded as return");
  a_ret_two_cycles: assert property (
    (q4 && is_ret_sub) |=> (state_reg == ST_IDLE_CYC)[*4]
      ##1 (state_reg == ST_IDLE))
    else $error("subroutine return timing wrong");
  a_idle_no_flags: assert property (
    (state_reg == ST_IDLE_CYC) |=> $stable(cpu_stat_reg)
      && $stable(alu_stat_reg) && $stable(work_reg))
    else $error("state changed in idle instruction cycle");
  a_rotate_work: assert property (
    (q4 && is_rot && !dest_file) |=>
      (work_reg == {$past(operand_reg[6:0]), $past(alu_stat_reg[0])})
      && (alu_stat_reg[CARRY_BIT] == $past(operand_reg[7]))
      && $stable(cpu_stat_reg))
    else $error("rotate to working register wrong");
  a_rotate_file: assert property (
    (q4 && dest_file) |-> mem_we && (mem_wdata == rot_val)
      ##1 $stable(work_reg))
    else $error("rotate to file register wrong");
  a_literal_return: assert property (
    (q4 && is_ret_lit) |=> (work_reg == $past(instr_reg[7:0]))
      && (pc_reg == $past(stack_top)) && (state_reg == ST_IDLE_CYC))
    else $error("literal return wrong");

endmodule // return_rotate_instr_exec

// ===== verif/tb.sv
// Self-checking bench for the return and rotate-through-carry executor
module tb
  import rr_exec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ***************************************************************
  // Design ports and bench state
  // ***************************************************************
  logic        clk_sys;        // 20 MHz system clock
  logic        nrst;           // Active low reset
  logic [11:0] awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [11:0] araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [15:0] stack_top;      // Far stack, driven by the bench
  logic        stack_pop;
  int          err_total = 0;  // Mismatches seen
  int          n_checks  = 0;  // Comparisons made
  int          pops      = 0;  // Stack pop pulses seen
  int          cyc       = 0;  // Cycles since time zero

  return_rotate_instr_exec return_rotate_instr_exec_inst (
    .clk_sys(clk_sys), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .stack_top(stack_top), .stack_pop(stack_pop));

  // Clock: one inversion each half period
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Pop counter, and a ceiling well above the expected run length
  always @(posedge clk_sys) begin
    cyc++;
    if (stack_pop === 1'b1) begin
      pops++;
    end
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end

  // ***************************************************************
  // Comparison, verdict and bus tasks
  // ***************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Ready is combinational on held state, so it is looked at mid-cycle
  // and the handshake then completes on the following rising edge
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                        output logic [1:0] resp);
    logic ta, tw, aw_d, w_d, b_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    b_d = 1'b0;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_d && w_d)) begin
      @(negedge clk_sys);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge clk_sys);
      if (ta) begin
        awvalid <= 1'b0;
        aw_d = 1'b1;
      end
      if (tw) begin
        wvalid <= 1'b0;
        w_d = 1'b1;
      end
    end
    bready <= 1'b1;
    while (!b_d) begin
      @(negedge clk_sys);
      b_d = bvalid;
      resp = bresp;
      @(posedge clk_sys);
    end
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
                        output logic [1:0] resp);
    logic t;
    t = 1'b0;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    while (!t) begin
      @(negedge clk_sys);
      t = arready;
      @(posedge clk_sys);
    end
    arvalid <= 1'b0;
    rready <= 1'b1;
    t = 1'b0;
    while (!t) begin
      @(negedge clk_sys);
      t = rvalid;
      d = rdata;
      resp = rresp;
      @(posedge clk_sys);
    end
    rready <= 1'b0;
  endtask

  task automatic wr_ok(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    check({30'h0, r}, {30'h0, RESP_OKAY}, "write resp");
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e,
                        input string w);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    check({30'h0, r}, {30'h0, RESP_OKAY}, "read resp");
    check(d, e, w);
  endtask

  // The status read stalls while the instruction runs, so it ends after
  task automatic exec(input logic [15:0] op);
    wr_ok(OFF_INSTR, {16'h0000, op});
    rd_chk(OFF_EXEC_STAT, 32'h00000000, "exec status");
  endtask

  function automatic logic [11:0] faddr(input logic [7:0] f);
    return {MEM_SEL, f, 2'h0};
  endfunction

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  // Reset values before any write
  task automatic t_reset();
    rd_chk(OFF_WORK, {24'h0, WORK_RST}, "working reset");
    rd_chk(OFF_CPU_STAT, {24'h0, CPU_STAT_RST}, "cpu reset");
    rd_chk(OFF_ALU_STAT, {24'h0, ALU_STAT_RST}, "alu reset");
    rd_chk(OFF_PC, {16'h0, PC_RST}, "pc reset");
    rd_chk(OFF_PC_HIGH, {24'h0, PC_HIGH_RST}, "latch reset");
  endtask

  task automatic t_returns();
    int p0;
    wr_ok(OFF_CPU_STAT, 32'h000000FF);
    wr_ok(OFF_PC_HIGH, 32'h0000005A);
    wr_ok(OFF_ALU_STAT, 32'h00000001);
    // A stale counter value must be overwritten by the popped one
    wr_ok(OFF_PC, 32'h00007777);
    stack_top <= 16'h1234;
    p0 = pops;
    rd_chk(OFF_STACK_TOP, 32'h00001234, "stack view");
    exec(OP_RET_IRQ);
    rd_chk(OFF_PC, 32'h00001234, "pc irq return");
    rd_chk(OFF_PC_HIGH, 32'h0000005A, "high latch");
    rd_chk(OFF_CPU_STAT, 32'h000000EF, "cpu status");
    rd_chk(OFF_ALU_STAT, 32'h00000001, "alu status");
    check(32'(pops - p0), 32'h00000001, "pops");
    // Two subroutine returns back to back, each pops exactly once
    wr_ok(OFF_CPU_STAT, 32'h000000FF);
    stack_top <= 16'hBEEF;
    p0 = pops;
    exec(OP_RET_SUB);
    rd_chk(OFF_PC, 32'h0000BEEF, "pc sub return");
    stack_top <= 16'h0F0F;
    exec(OP_RET_SUB);
    rd_chk(OFF_PC, 32'h00000F0F, "pc sub return 2");
    rd_chk(OFF_CPU_STAT, 32'h000000FF, "cpu status");
    rd_chk(OFF_ALU_STAT, 32'h00000001, "alu status");
    check(32'(pops - p0), 32'h00000002, "pops");
    // Literal return
    wr_ok(OFF_WORK, 32'h0000003C);
    stack_top <= 16'h4321;
    p0 = pops;
    exec({OP_RET_LIT, 8'hA5});
    rd_chk(OFF_WORK, 32'h000000A5, "working");
    rd_chk(OFF_PC, 32'h00004321, "pc literal");
    rd_chk(OFF_PC_HIGH, 32'h0000005A, "high latch");
    check(32'(pops - p0), 32'h00000001, "pops");
  endtask

  // Both destinations, both carry values, lowest and highest file address
  task automatic t_rotate();
    logic [7:0] f, v, r;
    logic       d, c;
    int         p0;
    for (int i = 0; i < 4; i++) begin
      f = 8'(i * 85);
      v = (i > 1) ? 8'h35 : 8'hE6;
      d = i[0];
      c = i[0] ^ i[1];
      r = {v[6:0], c};
      wr_ok(faddr(f), {24'h0, v});
      wr_ok(OFF_WORK, 32'h00000099);
      wr_ok(OFF_ALU_STAT, {31'h0, c});
      p0 = pops;
      exec({OP_ROT_LC, d, f});
      rd_chk(OFF_ALU_STAT, {31'h0, v[7]}, "carry");
      rd_chk(OFF_WORK, {24'h0, d ? 8'h99 : r}, "working");
      rd_chk(faddr(f), {24'h0, d ? r : v}, "file");
      rd_chk(OFF_CPU_STAT, 32'h000000FF, "cpu status");
      rd_chk(OFF_PC, 32'h00004321, "pc kept");
      check(32'(pops - p0), 32'h00000000, "pops");
    end
  endtask

  // Unknown opcode and unmapped address are refused
  task automatic t_refuse();
    logic [31:0] d;
    logic [1:0]  r;
    int          p0;
    p0 = pops;
    wr_ok(OFF_INSTR, 32'h00000000);
    rd_chk(OFF_EXEC_STAT, 32'h00000002, "illegal set");
    check(32'(pops - p0), 32'h00000000, "pops");
    wr_ok(OFF_EXEC_STAT, 32'h00000002);
    rd_chk(OFF_EXEC_STAT, 32'h00000000, "illegal clear");
    axi_wr(12'h020, 32'h000000FF, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write");
    axi_rd(12'h020, d, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped read");
    check(d, 32'h00000000, "unmapped data");
  endtask

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial begin
    nrst = 1'b0;
    awaddr = 12'h000;
    awvalid = 1'b0;
    wdata = 32'h00000000;
    wstrb = 4'hF;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 12'h000;
    arvalid = 1'b0;
    rready = 1'b0;
    stack_top = 16'h0000;
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_reset();
    t_returns();
    t_rotate();
    t_refuse();
    results();
  end

endmodule // tb
